// ===== hw/drop_frame_counter.sv
// Purpose: Drop-frame time code counter with daily and manual jam sync.
// Assumes: frame_tick is a one-cycle pulse per video frame from clk logic.
// Notes:   Configuration inputs are static levels from the same clock domain.
module drop_frame_counter (
    // Clock and reset.
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    // Frame timing and rate selection.
    input  wire logic                     frame_tick,
    input  wire logic                     rate_60,
    input  wire logic                     drop_frame,
    // Jam sync control.
    input  wire timecode_pkg::jam_cfg_s   jam_cfg,
    input  wire logic                     sync_now,
    // Time code and jam report outputs.
    output timecode_pkg::timecode_s       timecode,
    output logic                          jam_done,
    output logic [2:0]                    jam_skipped
);
    import timecode_pkg::*;

    // Overview of the data path.
    // The time code word is one register that advances on each frame tick.
    // A minute rollover reloads the frame field with a start value that holds
    // the normal drop size, or zero on a decade minute or at an integer rate.
    // A pending jam adds its extra count to that start value at the same rollover,
    // so a jam never creates a second, separate discontinuity in the count.
    // The drift accumulator keeps the uncounted fraction of frames in thousandths.
    // In drop mode it grows once per counted hour and is debited by each jam that is applied.
    // All inputs except rst_b come from logic on clk, so none of them is resynchronised here.
    // Only the reset release is synchronised, because rst_b comes from a pin.

    logic        rst_meta;
    logic        rst_sync_b;
    logic [15:0] drift;
    logic        jam_pending;
    logic        sched_armed;
    logic [5:0]  frame_last;
    logic [5:0]  drop_count;
    logic [5:0]  next_frame_start;
    logic [2:0]  next_extra;
    logic        minute_roll;
    logic        hour_roll;
    logic        sched_hit;
    logic [5:0]  next_minute;
    logic        jam_apply;
    logic [15:0] drift_cut;
    logic [15:0] drift_base;
    logic [15:0] next_drift;

    // Reset release passes through two flip-flops.
    // Assertion stays asynchronous so the counter clears even without a clock.
    // Release is retimed so that no register leaves reset on a different edge.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta   <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_b <= rst_meta;
        end
    end

    // Rate dependent limits and drop sizes.
    // The minute and hour rollover flags are decoded from the current word,
    // so they are only acted on when a frame tick is present.
    always_comb begin
        frame_last  = rate_60 ? FRAME_LAST_60 : FRAME_LAST_30;
        drop_count  = rate_60 ? DROP_60 : DROP_30;
        minute_roll = (timecode.frames == frame_last) && (timecode.seconds == SEC_LAST);
        hour_roll   = minute_roll && (timecode.minutes == MIN_LAST);
        next_minute = hour_roll ? FIELD_RESET : timecode.minutes + 6'h01;
    end

    // Extra skip: drift rounded to nearest even count, never zero and never above four.
    // An odd skip would shift the frame field out of step with the two-count
    // drop pattern, so only two or four counts are ever removed.
    // Three frames is the midpoint between the two choices.
    always_comb begin
        if (drift >= DRIFT_THREE) begin
            next_extra = 3'h4;
        end else begin
            next_extra = 3'h2;
        end
    end

    // Frame field start value for the coming second.
    // The decade test looks at the minute being entered, not the one being left.
    // The largest start value is the 60 rate drop plus four, well inside the field.
    always_comb begin
        next_frame_start = FIELD_RESET;
        if (minute_roll && drop_frame && (next_minute % MIN_DECADE != 6'h00)) begin
            next_frame_start = drop_count;
        end else if (minute_roll) begin
            next_frame_start = FIELD_RESET;
        end
        if (jam_pending && minute_roll) begin
            next_frame_start = next_frame_start + {3'h0, next_extra};
        end
    end

    // Daily match on the scheduled local hour and minute.
    // The match stays high for the whole scheduled minute, and the arm flag
    // below turns that level into a single request per day.
    assign sched_hit = jam_cfg.enable && (timecode.hours == jam_cfg.hours)
                       && (timecode.minutes == jam_cfg.minutes);

    // A jam is applied on the tick that rolls the minute while one is pending.
    always_comb begin
        jam_apply = frame_tick && jam_pending && minute_roll;
    end

    // Time code counter advanced on each frame tick.
    // Fields are binary counts; a display stage is expected to convert them.
    // Between ticks the word holds still, so readers may sample it at any cycle.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            timecode <= '0;
        end else if (frame_tick) begin
            if (timecode.frames == frame_last) begin
                timecode.frames <= (timecode.seconds == SEC_LAST) ? next_frame_start : FIELD_RESET;
                if (timecode.seconds == SEC_LAST) begin
                    timecode.seconds <= FIELD_RESET;
                    timecode.minutes <= next_minute;
                    if (hour_roll) begin
                        timecode.hours <= (timecode.hours == HOUR_LAST) ? 5'h00 : timecode.hours + 5'h01;
                    end
                end else begin
                    timecode.seconds <= timecode.seconds + 6'h01;
                end
            end else begin
                timecode.frames <= timecode.frames + 6'h01;
            end
        end
    end

    // Jam request: scheduled once per day, or at once on request.
    // A sync_now request that arrives on the rollover tick itself is kept for the next
    // minute, so no request is lost between setting and clearing.
    // Several manual requests before one rollover merge into a single jam.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            jam_pending <= 1'b0;
            sched_armed <= 1'b1;
        end else begin
            if (sync_now) begin
                jam_pending <= 1'b1;
            end else if (frame_tick && minute_roll) begin
                jam_pending <= 1'b0;
            end
            if (sched_hit && sched_armed && !(frame_tick && minute_roll)) begin
                jam_pending <= 1'b1;
                sched_armed <= 1'b0;
            end else if (!sched_hit) begin
                sched_armed <= 1'b1;
            end
        end
    end

    // Drift bookkeeping for the coming tick.
    // The hour credit is added before the jam debit, so a jam that lands on an
    // hour rollover does not lose that hour's share of drift.
    // The debit is floored at zero: skipping more than the drift never owes frames.
    always_comb begin
        drift_cut  = {13'h0, next_extra} * DRIFT_ONE;
        drift_base = drift;
        if (hour_roll) begin
            drift_base = drift + DRIFT_PER_HOUR;
        end
        next_drift = drift_base;
        if (jam_apply) begin
            next_drift = (drift_base > drift_cut) ? drift_base - drift_cut : 16'h0000;
        end
    end

    // Drift accumulator: grows each counted hour, shrinks by each jam.
    // Integer rates carry no drift, so the accumulator only moves in drop mode.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            drift <= 16'h0000;
        end else if (frame_tick && drop_frame) begin
            drift <= next_drift;
        end
    end

    // Completion report: one-cycle pulse and the extra count skipped.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            jam_done    <= 1'b0;
            jam_skipped <= 3'h0;
        end else begin
            jam_done <= jam_apply;
            if (jam_apply) begin
                jam_skipped <= next_extra;
            end
        end
    end

    // Limitations for users of this block.
    // The jam is applied at the minute rollover that follows the request, so a
    // scheduled jam lands one minute after the configured time.
    // With the daily jam disabled in drop mode the drift keeps growing and the
    // extra skip of a later manual jam is capped at four counts.
    // The counter wraps at the end of the day and carries no date.

endmodule : drop_frame_counter

// ===== hw/timecode_pkg.sv
// Purpose: Shared constants and carriers for the drop-frame time code counter.
// Assumes: One 50 MHz clock; frame ticks arrive from the same clock domain.
// Notes:   Time code fields are held as plain binary counts.
package timecode_pkg;

    // Field limits of the time code.
    localparam logic [5:0] FRAME_LAST_30  = 6'h1D;
    localparam logic [5:0] FRAME_LAST_60  = 6'h3B;
    localparam logic [5:0] SEC_LAST       = 6'h3B;
    localparam logic [5:0] MIN_LAST       = 6'h3B;
    localparam logic [4:0] HOUR_LAST      = 5'h17;
    localparam logic [5:0] MIN_DECADE     = 6'h0A;

    // Counts dropped at each non-decade minute, per frame rate.
    localparam logic [5:0] DROP_30        = 6'h02;
    localparam logic [5:0] DROP_60        = 6'h04;

    // Drift accounting: one unit is a thousandth of a frame at the 30 rate.
    // Each true hour leaves 0.108 frames uncounted, about 2.6 frames a day.
    localparam logic [15:0] DRIFT_PER_HOUR = 16'h006C;
    localparam logic [15:0] DRIFT_ONE      = 16'h03E8;
    localparam logic [15:0] DRIFT_THREE    = 16'h0BB8;

    // Reset value of the time code.
    localparam logic [5:0] FIELD_RESET    = 6'h00;

    // Time code value carried as one word.
    typedef struct packed {
        logic [4:0] hours;
        logic [5:0] minutes;
        logic [5:0] seconds;
        logic [5:0] frames;
    } timecode_s;

    // Scheduled jam sync setup supplied by configuration software.
    typedef struct packed {
        logic       enable;
        logic [4:0] hours;
        logic [5:0] minutes;
    } jam_cfg_s;

endpackage : timecode_pkg

// ===== verification/dfc_properties.sv
// Purpose: Port checks for the drop-frame counter.
// Assumes: 30 or 60 rate, ticks from the clk domain.
// Notes:   Bound to the design from tb_top.
module dfc_properties import timecode_pkg::*; (
    // Watched ports.
    input wire logic                   clk,
    input wire logic                   rst_b,
    input wire logic                   frame_tick,
    input wire logic                   rate_60,
    input wire logic                   drop_frame,
    input wire timecode_pkg::jam_cfg_s jam_cfg,
    input wire logic                   sync_now,
    input wire timecode_pkg::timecode_s timecode,
    input wire logic                   jam_done,
    input wire logic [2:0]             jam_skipped
);
    timeunit 1ns;
    timeprecision 1ns;
    logic to_decade;
    // High when the coming minute is a multiple of ten.
    assign to_decade = ((timecode.minutes + 6'h01) % MIN_DECADE) == 6'h00;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence min_end;
        frame_tick && !rate_60 && timecode.frames == FRAME_LAST_30 && timecode.seconds == SEC_LAST;
    endsequence
    chk_frame_step: assert property (frame_tick && !rate_60 && timecode.frames < FRAME_LAST_30 |=>
        timecode.frames == $past(timecode.frames) + 6'h01) else $error("frame step wrong");
    chk_second_wrap: assert property (frame_tick && !rate_60 && timecode.frames == FRAME_LAST_30
        && timecode.seconds < SEC_LAST |=> timecode.frames == 6'h00
        && timecode.seconds == $past(timecode.seconds) + 6'h01) else $error("second wrap wrong");
    sequence min_end_60;
        frame_tick && rate_60 && timecode.frames == FRAME_LAST_60 && timecode.seconds == SEC_LAST;
    endsequence
    chk_minute_drop: assert property (min_end ##0 (!to_decade && drop_frame) |=>
        timecode.frames == DROP_30 + (jam_done ? 6'(jam_skipped) : 6'h00)) else $error("no drop");
    chk_decade_roll: assert property (min_end ##0 (to_decade || !drop_frame) |=>
        timecode.frames == (jam_done ? 6'(jam_skipped) : 6'h00)) else $error("bad roll");
    chk_drop_sixty: assert property (min_end_60 ##0 (!to_decade && drop_frame) |=>
        timecode.frames == DROP_60 + (jam_done ? 6'(jam_skipped) : 6'h00)) else $error("no drop at 60");
    chk_jam_size: assert property (jam_done |-> jam_skipped == 3'h2 || jam_skipped == 3'h4)
        else $error("jam size wrong");
    chk_jam_moment: assert property (jam_done |-> timecode.seconds == 6'h00
        && timecode.minutes != $past(timecode.minutes)) else $error("jam off minute");
    chk_hold_idle: assert property (!frame_tick |=> $stable(timecode)) else $error("moved idle");
    chk_reset_clear: assert property (disable iff (1'b0) !rst_b ##1 !rst_b |-> timecode == '0 && !jam_done)
        else $error("reset not clear");
endmodule : dfc_properties

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for the drop-frame counter.
// Assumes: One tick per cycle; jam scheduled for 00:10.
// Notes:   Runs about 14 counted minutes.
module tb_top import timecode_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic      clk = 1'b0;
    logic      rst_b = 1'b0;
    logic      frame_tick = 1'b0;
    logic      drop_frame = 1'b1;
    logic      rate_60 = 1'b0;
    logic      sync_now = 1'b0;
    jam_cfg_s  jam_cfg = '{enable: 1'b1, hours: 5'h00, minutes: 6'h0A};
    timecode_s timecode;
    logic      jam_done;
    logic [2:0] jam_skipped;
    int        mismatches = 0;
    int        num_checks = 0;
    // Clock of 50 MHz.
    always #10 clk = ~clk;
    drop_frame_counter DUT (.clk(clk), .rst_b(rst_b), .frame_tick(frame_tick), .rate_60(rate_60),
        .drop_frame(drop_frame), .jam_cfg(jam_cfg), .sync_now(sync_now), .timecode(timecode),
        .jam_done(jam_done), .jam_skipped(jam_skipped));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check
    // Waits, bounded, for the minutes field to reach m.
    task automatic wait_min(input logic [5:0] m);
        int n;
        for (n = 0; n < 20000 && timecode.minutes !== m; n++) begin
            @(posedge clk);
            #1;
        end
        if (timecode.minutes !== m) begin
            $display("[FAIL] %0t minute wait timed out", $time);
            mismatches++;
            give_verdict();
        end
    endtask : wait_min
    task automatic t_drop();
        wait_min(6'h01);
        check(timecode.frames === DROP_30 && timecode.seconds === 6'h00, "no drop at 01");
        $display("t_drop done");
    endtask : t_drop
    task automatic t_decade();
        wait_min(6'h0A);
        check(timecode.frames === 6'h00, "skip at 10");
        $display("t_decade done");
    endtask : t_decade
    task automatic t_sched();
        wait_min(6'h0B);
        check(timecode.frames === 6'h04, "scheduled jam frames");
        check(jam_done === 1'b1 && jam_skipped === 3'h2, "jam report");
        @(posedge clk);
        #1;
        check(jam_done === 1'b0, "jam pulse too long");
        $display("t_sched done");
    endtask : t_sched
    task automatic t_manual();
        @(posedge clk);
        sync_now <= 1'b1;
        @(posedge clk);
        sync_now <= 1'b0;
        wait_min(6'h0C);
        check(timecode.frames === 6'h04, "manual jam frames");
        $display("t_manual done");
    endtask : t_manual
    task automatic t_plain();
        @(posedge clk);
        drop_frame <= 1'b0;
        wait_min(6'h0D);
        check(timecode.frames === 6'h00, "integer rate skipped");
        $display("t_plain done");
    endtask : t_plain
    task automatic t_rate60();
        @(posedge clk);
        drop_frame <= 1'b1;
        rate_60    <= 1'b1;
        wait_min(6'h0E);
        check(timecode.frames === DROP_60, "no drop at 60 rate");
        $display("t_rate60 done");
    endtask : t_rate60
    // Main sequence: reset, then each scenario in minute order.
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        frame_tick <= 1'b1;
        t_drop();
        t_decade();
        t_sched();
        t_manual();
        t_plain();
        t_rate60();
        give_verdict();
    end
endmodule : tb_top
bind drop_frame_counter dfc_properties chk (.clk(clk), .rst_b(rst_b), .frame_tick(frame_tick),
    .rate_60(rate_60), .drop_frame(drop_frame), .jam_cfg(jam_cfg), .sync_now(sync_now),
    .timecode(timecode), .jam_done(jam_done), .jam_skipped(jam_skipped));
